/* File: design/cn_nmt_led.v */
// Controlled-node network-management state machine with indicator encoder.
`timescale 1ns/1ps
`include "cn_nmt_map.vh"

module cn_nmt_led #(
  parameter integer TIMEOUT_CYC = `FRAME_TIMEOUT_MS * `CLK_KHZ
) (
  input wire clk_i,
  input wire resetn_i,
  input wire init_done_i,
  input wire soc_i,
  input wire preq_i,
  input wire pres_i,
  input wire soa_i,
  input wire soa_grant_i,
  input wire comm_error_i,
  input wire start_node_i,
  input wire stop_node_i,
  input wire enter_preop2_ready_i,
  input wire link1_i,
  input wire act1_i,
  input wire link2_i,
  input wire act2_i,
  input wire module_power_i,
  input wire motor_comm_ok_i,
  input wire error_i,
  input wire boot_error_i,
  output reg [6:0] nmt_state_o,
  output wire async_tx_en_o,
  output wire pdo_consume_o,
  output wire pdo_produce_o,
  output wire pdo_maybe_invalid_o,
  output wire send_pres_o,
  output wire ready_flag_o,
  output reg state_indicator_o,
  output reg first_port_link_lamp_o,
  output reg second_port_link_lamp_o,
  output reg supply_indicator_o,
  output reg error_lamp_o
);

  // ----------------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------------
  localparam [6:0] S_NACT = `ST_NOT_ACTIVE;
  localparam [6:0] S_BETH = `ST_BASIC_ETH;
  localparam [6:0] S_PRE1 = `ST_PREOP1;
  localparam [6:0] S_PRE2 = `ST_PREOP2;
  localparam [6:0] S_RDY = `ST_READY;
  localparam [6:0] S_OPER = `ST_OPERATIONAL;
  localparam [6:0] S_STOP = `ST_STOPPED;

  reg [6:0] state_q;
  reg [6:0] state_d;
  reg [31:0] tmo_cnt_q;
  reg started_q;
  wire any_frame;
  wire blink;
  wire single;
  wire dbl;
  wire triple;
  wire flick;

  assign any_frame = soc_i | preq_i | pres_i | soa_i;

  // ----------------------------------------------------------------------
  // Node state machine
  // ----------------------------------------------------------------------
  // Hold in not-active until internal initialisation reports done.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      started_q <= 1'b0;
    end else if (init_done_i) begin
      started_q <= 1'b1;
    end
  end

  // Silence timer runs only while not active; any frame restarts it.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      tmo_cnt_q <= 32'h00000000;
    end else if (state_q != S_NACT || !started_q || any_frame) begin
      tmo_cnt_q <= 32'h00000000;
    end else if (tmo_cnt_q != TIMEOUT_CYC) begin
      tmo_cnt_q <= tmo_cnt_q + 32'h00000001;
    end
  end

  // Next state; errors in pre-op two, ready, operational and stopped outrank every other event.
  always @* begin
    state_d = state_q;
    case (state_q)
      S_NACT: begin
        if (started_q && (soa_i || soc_i)) begin
          state_d = S_PRE1;
        end else if (started_q && tmo_cnt_q == TIMEOUT_CYC) begin
          state_d = S_BETH;
        end
      end
      S_BETH: begin
        // Basic Ethernet is left when managed traffic shows up again.
        if (soa_i || soc_i) begin
          state_d = S_PRE1;
        end
      end
      S_PRE1: begin
        if (soc_i) begin
          state_d = S_PRE2;
        end
      end
      S_PRE2: begin
        if (comm_error_i) begin
          state_d = S_PRE1;
        end else if (enter_preop2_ready_i) begin
          state_d = S_RDY;
        end
      end
      S_RDY: begin
        if (comm_error_i) begin
          state_d = S_PRE1;
        end else if (start_node_i) begin
          state_d = S_OPER;
        end
      end
      S_OPER: begin
        if (comm_error_i) begin
          state_d = S_PRE1;
        end else if (stop_node_i) begin
          state_d = S_STOP;
        end
      end
      S_STOP: begin
        if (comm_error_i) begin
          state_d = S_PRE1;
        end else if (start_node_i) begin
          state_d = S_OPER;
        end
      end
      default: begin
        state_d = S_NACT;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q <= S_NACT;
      nmt_state_o <= S_NACT;
    end else begin
      state_q <= state_d;
      nmt_state_o <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Transmission gating
  // ----------------------------------------------------------------------
  // Asynchronous send needs a grant; stopped still watches async starts.
  assign async_tx_en_o = soa_grant_i && (state_q != S_NACT) && (state_q != S_BETH);
  // No cyclic data before pre-op two nor while stopped.
  assign pdo_consume_o = (state_q == S_PRE2) || (state_q == S_RDY) ||
                         (state_q == S_OPER);
  assign pdo_produce_o = (state_q == S_RDY) || (state_q == S_OPER);
  assign pdo_maybe_invalid_o = (state_q == S_PRE2);
  // Poll request is answered once cyclic exchange is allowed.
  assign send_pres_o = preq_i && (state_q == S_PRE2 || state_q == S_RDY ||
                                  state_q == S_OPER);
  assign ready_flag_o = (state_q == S_RDY) || (state_q == S_OPER);

  // ----------------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------------
  lamp_pattern_gen u_pat (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .blink_o(blink),
    .single_o(single),
    .double_o(dbl),
    .triple_o(triple),
    .flicker_o(flick)
  );

  // ----------------------------------------------------------------------
  // Pattern decoding
  // ----------------------------------------------------------------------
  // Map a node state onto its indicator pattern code.
  function [2:0] state_pattern;
    input [6:0] st;
    begin
      if (st == S_OPER) begin
        state_pattern = `PAT_ON;
      end else if (st == S_STOP) begin
        state_pattern = `PAT_BLINK;
      end else if (st == S_PRE1) begin
        state_pattern = `PAT_SINGLE;
      end else if (st == S_PRE2) begin
        state_pattern = `PAT_DOUBLE;
      end else if (st == S_RDY) begin
        state_pattern = `PAT_TRIPLE;
      end else if (st == S_BETH) begin
        state_pattern = `PAT_FLICKER;
      end else begin
        state_pattern = `PAT_OFF;
      end
    end
  endfunction

  // Turn a pattern code into the lamp level for this cycle.
  // An unknown code shows dark, so a stray value never lights a lamp.
  function pattern_level;
    input [2:0] code;
    input bl;
    input sg;
    input db;
    input tr;
    input fl;
    begin
      case (code)
        `PAT_ON: begin
          pattern_level = 1'b1;
        end
        `PAT_BLINK: begin
          pattern_level = bl;
        end
        `PAT_SINGLE: begin
          pattern_level = sg;
        end
        `PAT_DOUBLE: begin
          pattern_level = db;
        end
        `PAT_TRIPLE: begin
          pattern_level = tr;
        end
        `PAT_FLICKER: begin
          pattern_level = fl;
        end
        default: begin
          pattern_level = 1'b0;
        end
      endcase
    end
  endfunction

  // Pattern codes of the three status lamps; all share one decoder.
  wire [2:0] state_code;
  wire [2:0] supply_code;
  wire [2:0] error_code;
  assign state_code = state_pattern(state_q);
  assign supply_code = !module_power_i ? `PAT_OFF :
                       (motor_comm_ok_i ? `PAT_ON : `PAT_FLICKER);
  // Boot failure outranks an ordinary error.
  assign error_code = boot_error_i ? `PAT_FLICKER :
                      (error_i ? `PAT_ON : `PAT_OFF);

  // Link lamp is shared by both ports, so it is a function.
  function link_lamp;
    input link;
    input act;
    input fl;
    begin
      link_lamp = link & (act ? fl : 1'b1);
    end
  endfunction

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      state_indicator_o <= 1'b0;
      first_port_link_lamp_o <= 1'b0;
      second_port_link_lamp_o <= 1'b0;
      supply_indicator_o <= 1'b0;
      error_lamp_o <= 1'b0;
    end else begin
      state_indicator_o <= pattern_level(state_code, blink, single, dbl, triple,
                                         flick);
      first_port_link_lamp_o <= link_lamp(link1_i, act1_i, flick);
      second_port_link_lamp_o <= link_lamp(link2_i, act2_i, flick);
      supply_indicator_o <= pattern_level(supply_code, blink, single, dbl, triple,
                                          flick);
      error_lamp_o <= pattern_level(error_code, blink, single, dbl, triple,
                                    flick);
    end
  end

endmodule // cn_nmt_led

/* File: design/cn_nmt_map.vh */
// Constants for the controlled-node state machine and its indicator encoder.
`ifndef CN_NMT_MAP_VH
`define CN_NMT_MAP_VH

// Clock rate in kHz and pattern times in ms.
`define CLK_KHZ 200000
`define BLINK_MS 200
`define FLASH_OFF_MS 1000
`define FLICKER_MS 50
`define FRAME_TIMEOUT_MS 100

// One-hot state codes of the node state machine.
`define ST_NOT_ACTIVE 7'h01
`define ST_BASIC_ETH 7'h02
`define ST_PREOP1 7'h04
`define ST_PREOP2 7'h08
`define ST_READY 7'h10
`define ST_OPERATIONAL 7'h20
`define ST_STOPPED 7'h40

// Indicator pattern codes.
`define PAT_OFF 3'h0
`define PAT_ON 3'h1
`define PAT_BLINK 3'h2
`define PAT_SINGLE 3'h3
`define PAT_DOUBLE 3'h4
`define PAT_TRIPLE 3'h5
`define PAT_FLICKER 3'h6

`endif

/* File: design/lamp_pattern_gen.v */
// Indicator pattern timebase: blink, flash and flicker waveforms.
`timescale 1ns/1ps
`include "cn_nmt_map.vh"

module lamp_pattern_gen (
  input wire clk_i,
  input wire resetn_i,
  output reg blink_o,
  output reg single_o,
  output reg double_o,
  output reg triple_o,
  output reg flicker_o
);

  // ----------------------------------------------------------------------
  // Timebase constants
  // ----------------------------------------------------------------------
  localparam integer MS_CYC = `CLK_KHZ;
  localparam integer TICK_LAST = `BLINK_MS * MS_CYC - 1;
  localparam integer FLICK_LAST = (`FLICKER_MS * MS_CYC) / 2 - 1;
  localparam integer OFF_SLOTS = `FLASH_OFF_MS / `BLINK_MS;

  reg [25:0] tick_cnt_q;
  reg [22:0] flick_cnt_q;
  reg tick_200;
  wire [2:0] flash_on;

  // One-cycle enable every 200 ms from the single system clock.
  always @* begin
    tick_200 = (tick_cnt_q == TICK_LAST[25:0]);
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      tick_cnt_q <= 26'h0000000;
      flick_cnt_q <= 23'h000000;
      blink_o <= 1'b0;
      flicker_o <= 1'b0;
    end else begin
      tick_cnt_q <= tick_200 ? 26'h0000000 : tick_cnt_q + 26'h0000001;
      if (flick_cnt_q == FLICK_LAST[22:0]) begin
        flick_cnt_q <= 23'h000000;
        flicker_o <= ~flicker_o;
      end else begin
        flick_cnt_q <= flick_cnt_q + 23'h000001;
      end
      if (tick_200) begin
        blink_o <= ~blink_o;
      end
    end
  end

  // Each flash pattern owns a 200 ms slot counter, so every one of them
  // ends in exactly 1 s of dark; a shared frame would stretch the gap.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : flash_slot
      localparam integer WRAP = 2 * g + OFF_SLOTS;
      localparam integer LAST_ON = 2 * g;
      reg [3:0] ph_q;
      always @(posedge clk_i) begin
        if (!resetn_i) begin
          ph_q <= 4'h0;
        end else if (tick_200) begin
          ph_q <= (ph_q == WRAP[3:0]) ? 4'h0 : ph_q + 4'h1;
        end
      end
      assign flash_on[g] = !ph_q[0] && (ph_q <= LAST_ON[3:0]);
    end
  endgenerate

  // Flash waveforms are registered so the lamps never see decode glitches.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      single_o <= 1'b0;
      double_o <= 1'b0;
      triple_o <= 1'b0;
    end else begin
      single_o <= flash_on[0];
      double_o <= flash_on[1];
      triple_o <= flash_on[2];
    end
  end

endmodule // lamp_pattern_gen

/* File: test/cn_nmt_led_asserts.sv */
// Concurrent checks on the state machine outputs of the controlled node.
`timescale 1ns/1ps
module cn_nmt_led_asserts (
  input wire clk_i,
  input wire resetn_i,
  input wire init_done_i,
  input wire soc_i,
  input wire preq_i,
  input wire soa_grant_i,
  input wire comm_error_i,
  input wire start_node_i,
  input wire [6:0] nmt_state_o,
  input wire async_tx_en_o,
  input wire pdo_consume_o,
  input wire pdo_produce_o,
  input wire pdo_maybe_invalid_o,
  input wire send_pres_o,
  input wire ready_flag_o
);
  // ----------------------------------------
  // State transitions and gating
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_nact_cycle_start: assert property (nmt_state_o == 7'h01 && soc_i && $past(init_done_i)
    |=> nmt_state_o == 7'h04) else $error("cycle start did not leave not-active");
  chk_preop_one_up: assert property (nmt_state_o == 7'h04 && soc_i && !comm_error_i
    |=> nmt_state_o == 7'h08) else $error("cycle start did not reach pre-op two");
  chk_error_falls_back: assert property ((nmt_state_o & 7'h78) != 7'h00 && comm_error_i
    |=> nmt_state_o == 7'h04) else $error("error did not return to pre-op one");
  chk_async_grant_gate: assert property (nmt_state_o == 7'h04
    |-> async_tx_en_o == soa_grant_i) else $error("async send not tied to grant");
  chk_preop_one_quiet: assert property (nmt_state_o == 7'h04
    |-> !pdo_consume_o && !pdo_produce_o) else $error("process data in pre-op one");
  chk_payload_doubt: assert property (pdo_maybe_invalid_o == (nmt_state_o == 7'h08))
    else $error("payload doubt flag wrong");
  chk_ready_answers: assert property (nmt_state_o == 7'h10 && preq_i
    |-> send_pres_o && ready_flag_o) else $error("ready node did not answer");
  chk_start_command: assert property (nmt_state_o == 7'h20 && $past(nmt_state_o) != 7'h20
    |-> $past(start_node_i)) else $error("operational without start command");
  chk_stopped_silent: assert property (nmt_state_o == 7'h40
    |-> !pdo_consume_o && !pdo_produce_o && !send_pres_o) else $error("stopped node exchanged");
endmodule // cn_nmt_led_asserts

/* File: test/mn_frame_source.sv */
// Managing-node model: frame and command pulses toward the node.
`timescale 1ns/1ps
module mn_frame_source (
  input wire clk_i,
  input wire send_pres_i,
  output logic [6:0] frame_o,
  output logic answered_o
);
  // Bits: cycle start, poll request, poll response, async start, start, stop, ready entry.
  initial frame_o = 7'h00;
  initial answered_o = 1'b0;
  // The answer is taken at the edge that takes the poll request.
  always @(posedge clk_i) if (frame_o[1]) answered_o <= send_pres_i;
  // One pulse per call; the gap edge keeps two calls from merging.
  task issue(input int k);
    @(posedge clk_i);
    frame_o <= 7'h01 << k;
    @(posedge clk_i);
    frame_o <= 7'h00;
  endtask
endmodule // mn_frame_source

/* File: test/cn_nmt_led_tb.sv */
// Self-checking bench for the node state machine and its lamps.
`timescale 1ns/1ps
module cn_nmt_led_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic init_done_i = 1'b0;
  logic comm_error_i = 1'b0;
  logic grant = 1'b0;
  logic [7:0] lv = 8'h00; // Link1, act1, link2, act2, power, motor ok, error, boot error.
  wire [6:0] fr;
  wire [6:0] st;
  wire [10:0] o;
  wire answered;
  int num_errors = 0;
  int tests_run = 0;
  cn_nmt_led #(.TIMEOUT_CYC(50)) i_cn_nmt_led (.clk_i(clk_i), .resetn_i(resetn_i),
    .init_done_i(init_done_i), .soc_i(fr[0]), .preq_i(fr[1]), .pres_i(fr[2]), .soa_i(fr[3]),
    .soa_grant_i(grant), .comm_error_i(comm_error_i), .start_node_i(fr[4]),
    .stop_node_i(fr[5]), .enter_preop2_ready_i(fr[6]), .link1_i(lv[0]), .act1_i(lv[1]),
    .link2_i(lv[2]), .act2_i(lv[3]), .module_power_i(lv[4]), .motor_comm_ok_i(lv[5]),
    .error_i(lv[6]), .boot_error_i(lv[7]), .nmt_state_o(st), .async_tx_en_o(o[0]),
    .pdo_consume_o(o[1]), .pdo_produce_o(o[2]), .pdo_maybe_invalid_o(o[3]),
    .send_pres_o(o[4]), .ready_flag_o(o[5]), .state_indicator_o(o[6]),
    .first_port_link_lamp_o(o[7]), .second_port_link_lamp_o(o[8]),
    .supply_indicator_o(o[9]), .error_lamp_o(o[10]));
  mn_frame_source i_mn_frame_source (.clk_i(clk_i), .send_pres_i(o[4]), .frame_o(fr),
    .answered_o(answered));
  // ----------------------------------------
  // Clock, compare and helpers
  // ----------------------------------------
  initial forever #2.5 clk_i = ~clk_i;
  task chk(input logic [6:0] got, input logic [6:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Reset is long on purpose so every pattern counter is cleared too.
  task do_reset;
    @(posedge clk_i);
    resetn_i <= 1'b0;
    init_done_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    init_done_i <= 1'b1;
    #1;
  endtask
  task err_pulse(input logic [6:0] exp);
    @(posedge clk_i);
    comm_error_i <= 1'b1;
    @(posedge clk_i);
    comm_error_i <= 1'b0;
    #1 chk(st, exp);
  endtask
  task go(input int k, input logic [6:0] exp);
    i_mn_frame_source.issue(k);
    #1 chk(st, exp);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_timeout;
    do_reset();
    chk(st, 7'h01);
    chk({2'h0, o[10:6]}, 7'h00);
    repeat (60) @(posedge clk_i);
    #1 chk(st, 7'h02);
    go(3, 7'h04);
  endtask
  task t_walk;
    do_reset();
    go(3, 7'h04);
    @(posedge clk_i) grant <= 1'b1;
    #1 chk({6'h00, o[0]}, 7'h01);
    chk({5'h00, o[2:1]}, 7'h00);
    chk({6'h00, o[6]}, 7'h01);
    @(posedge clk_i) grant <= 1'b0;
    err_pulse(7'h04);
    go(0, 7'h08);
    chk({6'h00, o[3]}, 7'h01);
    go(4, 7'h08);
    err_pulse(7'h04);
    go(0, 7'h08);
    go(6, 7'h10);
    go(1, 7'h10);
    chk({5'h00, answered, o[5]}, 7'h03);
    go(4, 7'h20);
    repeat (3) @(posedge clk_i);
    #1 chk({6'h00, o[6]}, 7'h01);
    go(5, 7'h40);
    go(1, 7'h40);
    chk({6'h00, answered}, 7'h00);
    chk({6'h00, o[6]}, 7'h00);
    go(3, 7'h40);
  endtask
  task t_lamps;
    @(posedge clk_i) lv <= 8'h71;
    repeat (3) @(posedge clk_i);
    #1 chk({3'h0, o[10:7]}, 7'h0D);
    @(posedge clk_i) lv <= 8'hD7;
    repeat (3) @(posedge clk_i);
    #1 chk({3'h0, o[10:7]}, 7'h02);
    @(posedge clk_i) lv <= 8'h00;
    repeat (3) @(posedge clk_i);
    #1 chk({3'h0, o[10:7]}, 7'h00);
  endtask
  task close_out;
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // The whole run is about 120 cycles; this limit is far beyond it.
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
  initial begin
    t_timeout();
    t_walk();
    t_lamps();
    close_out();
  end
endmodule // cn_nmt_led_tb
bind cn_nmt_led cn_nmt_led_asserts i_cn_nmt_led_asserts (.*);
